// >>> cdsdma_defs.svh
// Constant definitions for the chained descriptor serial DMA engine
`ifndef CDSDMA_DEFS_SVH
`define CDSDMA_DEFS_SVH

// =====================================================================
// Register offsets (channel registers repeat every 8 words)
`define CDSDMA_CH_STRIDE    5'h08
`define CDSDMA_OFF_CPB      3'h0
`define CDSDMA_OFF_CDA      3'h1
`define CDSDMA_OFF_EDA      3'h2
`define CDSDMA_OFF_CTRL     3'h3
`define CDSDMA_OFF_BCNT     3'h4
`define CDSDMA_OFF_PHASE    3'h5
`define CDSDMA_OFF_BFL      5'h10

// =====================================================================
// Control field positions
`define CDSDMA_CTRL_RUN     0
`define CDSDMA_CTRL_MULTI   1

// =====================================================================
// Descriptor byte offsets and status bits
`define CDSDMA_D_LINK_L     4'h0
`define CDSDMA_D_LINK_H     4'h1
`define CDSDMA_D_BUF_L      4'h2
`define CDSDMA_D_BUF_M      4'h3
`define CDSDMA_D_BUF_H      4'h4
`define CDSDMA_D_LEN_L      4'h6
`define CDSDMA_D_LEN_H      4'h7
`define CDSDMA_D_STAT       4'h8
`define CDSDMA_ST_EOM       7
`define CDSDMA_ST_EOT       6
`define CDSDMA_STAT_MID     8'h00

// =====================================================================
// Reset values and FIFO depth
`define CDSDMA_RST_BFL      16'h0000
`define CDSDMA_FIFO_DEPTH   2'h3

`endif

// >>> cdsdma_pkg.sv
// Types shared by the chained descriptor serial DMA engine
package cdsdma_pkg;

    // Per-channel phase, one-hot
    typedef enum logic [4:0] {
        PH_IDLE  = 5'b0_0001,
        PH_NEXT  = 5'b0_0010,
        PH_FETCH = 5'b0_0100,
        PH_XFER  = 5'b0_1000,
        PH_WBACK = 5'b1_0000
    } cdsdma_phase_e;

    // Context of one channel
    typedef struct packed {
        cdsdma_phase_e phase;
        logic [3:0]    idx;
        logic [3:0]    chain_pointer_base;
        logic [15:0]   current_descriptor_address;
        logic [15:0]   end_descriptor_address;
        logic [15:0]   link;
        logic [19:0]   baddr;
        logic [15:0]   byte_counter;
        logic [7:0]    dstat;
        logic          multi;
        logic          eof;
    } cdsdma_chan_s;

    // Three-entry byte FIFO; bit 8 of an entry marks end of frame
    typedef struct packed {
        logic [2:0][8:0] ent;
        logic [1:0]      head;
        logic [1:0]      cnt;
    } cdsdma_fifo_s;

    // Byte-wide memory master request
    typedef struct packed {
        logic        req;
        logic        we;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } cdsdma_mem_s;

    // Whole state of the engine
    typedef struct packed {
        cdsdma_chan_s [1:0] ch;
        cdsdma_fifo_s [1:0] fifo;
        cdsdma_mem_s        mem;
        logic               owner;
        logic [15:0]        receive_buffer_length;
        logic [7:0]         fstat;
        logic [15:0]        rdata;
    } cdsdma_state_s;

endpackage : cdsdma_pkg

// >>> cdsdma.sv
// Two-channel chained descriptor DMA between memory and the serial unit
`timescale 1ns/1ns
`include "cdsdma_defs.svh"
module cdsdma (
    input  wire logic                 clk_sys_in,
    input  wire logic                 resetn_in,
    // Register port
    input  wire logic [4:0]           reg_addr_in,
    input  wire logic [15:0]          reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic [15:0]               reg_rdata_out,
    // Memory master port
    output cdsdma_pkg::cdsdma_mem_s   mem_out,
    input  wire logic                 mem_ack_in,
    input  wire logic [7:0]           mem_rdata_in,
    // Receive bytes from the serial unit
    input  wire logic                 rx_valid_in,
    input  wire logic [7:0]           rx_data_in,
    input  wire logic                 rx_eof_in,
    input  wire logic [7:0]           rx_status_in,
    output logic                      rx_ready_out,
    // Transmit bytes to the serial unit
    output logic                      tx_valid_out,
    output logic [7:0]                tx_data_out,
    output logic                      tx_eom_out,
    input  wire logic                 tx_ready_in
);

    // =================================================================
    // State
    cdsdma_pkg::cdsdma_state_s st_reg;   // Registered state
    cdsdma_pkg::cdsdma_state_s st_next;  // Next state
    logic [1:0]                push;     // FIFO push per path
    logic [1:0]                pop;      // FIFO pop per path
    logic [1:0][8:0]           pdata;    // FIFO push data per path
    logic [1:0]                ready;    // Channel has a memory op
    logic [1:0]                tail;     // Scratch tail index
    logic [2:0]                tail_sum; // Tail before wrap, spare bit
    logic                      c;        // Scratch channel select
    logic [15:0]               used;     // Receive length written back
    logic                      fin;      // Scratch end of buffer

    // =================================================================
    // Outputs straight from state
    assign mem_out       = st_reg.mem;
    assign reg_rdata_out = st_reg.rdata;
    // Full FIFO back-pressures the receiver
    assign rx_ready_out  = st_reg.fifo[0].cnt != `CDSDMA_FIFO_DEPTH;
    assign tx_valid_out  = st_reg.fifo[1].cnt != 2'h0;
    assign tx_data_out   = st_reg.fifo[1].ent[st_reg.fifo[1].head][7:0];
    assign tx_eom_out    = st_reg.fifo[1].ent[st_reg.fifo[1].head][8];
    assign used = st_reg.receive_buffer_length
                - st_reg.ch[0].byte_counter;

    // =================================================================
    // Next-state logic for registers, channels, memory port and FIFOs
    always_comb begin
        st_next = st_reg;
        push    = 2'b00;
        pop     = 2'b00;
        pdata   = '0;
        c       = 1'b0;
        fin     = 1'b0;
        tail    = 2'h0;
        tail_sum = 3'h0;
        st_next.rdata = 16'h0000;

        // Register reads, answered next cycle; unmapped reads give zero
        if (reg_rd_in) begin
            if (reg_addr_in == `CDSDMA_OFF_BFL) begin
                st_next.rdata = st_reg.receive_buffer_length;
            end else if (reg_addr_in < 5'h10) begin
                c = reg_addr_in[3];
                case (reg_addr_in[2:0])
                    `CDSDMA_OFF_CPB:   st_next.rdata =
                        {12'h000, st_reg.ch[c].chain_pointer_base};
                    `CDSDMA_OFF_CDA:   st_next.rdata =
                        st_reg.ch[c].current_descriptor_address;
                    `CDSDMA_OFF_EDA:   st_next.rdata =
                        st_reg.ch[c].end_descriptor_address;
                    `CDSDMA_OFF_CTRL:  st_next.rdata = {14'h0000,
                        st_reg.ch[c].multi,
                        st_reg.ch[c].phase != cdsdma_pkg::PH_IDLE};
                    `CDSDMA_OFF_BCNT:  st_next.rdata =
                        st_reg.ch[c].byte_counter;
                    `CDSDMA_OFF_PHASE: st_next.rdata =
                        {11'h000, st_reg.ch[c].phase};
                    default:           st_next.rdata = 16'h0000;
                endcase
            end
        end

        // Register writes; the end address may change while running
        if (reg_wr_in) begin
            if (reg_addr_in == `CDSDMA_OFF_BFL) begin
                st_next.receive_buffer_length = reg_wdata_in;
            end else if (reg_addr_in < 5'h10) begin
                c = reg_addr_in[3];
                case (reg_addr_in[2:0])
                    `CDSDMA_OFF_CPB:  st_next.ch[c].chain_pointer_base =
                        reg_wdata_in[3:0];
                    `CDSDMA_OFF_CDA:
                        st_next.ch[c].current_descriptor_address =
                            reg_wdata_in;
                    `CDSDMA_OFF_EDA:
                        st_next.ch[c].end_descriptor_address =
                            reg_wdata_in;
                    `CDSDMA_OFF_CTRL: begin
                        // Start only from idle; no abort of a live chain
                        if (st_reg.ch[c].phase == cdsdma_pkg::PH_IDLE) begin
                            st_next.ch[c].multi =
                                reg_wdata_in[`CDSDMA_CTRL_MULTI];
                            if (reg_wdata_in[`CDSDMA_CTRL_RUN]) begin
                                st_next.ch[c].phase = cdsdma_pkg::PH_NEXT;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Receiver fills FIFO 0; status is caught with the last byte
        if (rx_valid_in && rx_ready_out) begin
            push[0]  = 1'b1;
            pdata[0] = {rx_eof_in, rx_data_in};
            if (rx_eof_in) begin
                st_next.fstat = rx_status_in;
            end
        end
        // Transmitter drains FIFO 1
        pop[1] = tx_valid_out && tx_ready_in;

        // Descriptor boundary: stop on end address, else fetch
        for (int k = 0; k < 2; k++) begin
            if (st_reg.ch[k].phase == cdsdma_pkg::PH_NEXT) begin
                st_next.ch[k].idx = 4'h0;
                if (st_reg.ch[k].current_descriptor_address ==
                    st_reg.ch[k].end_descriptor_address) begin
                    st_next.ch[k].phase = cdsdma_pkg::PH_IDLE;
                end else begin
                    st_next.ch[k].phase = cdsdma_pkg::PH_FETCH;
                end
            end
        end

        // Memory completion for the owning channel
        if (st_reg.mem.req && mem_ack_in) begin
            st_next.mem.req = 1'b0;
            c = st_reg.owner;
            case (st_reg.ch[c].phase)
                cdsdma_pkg::PH_FETCH: begin
                    case (st_reg.ch[c].idx)
                        `CDSDMA_D_LINK_L: st_next.ch[c].link[7:0] =
                            mem_rdata_in;
                        `CDSDMA_D_LINK_H: st_next.ch[c].link[15:8] =
                            mem_rdata_in;
                        `CDSDMA_D_BUF_L:  st_next.ch[c].baddr[7:0] =
                            mem_rdata_in;
                        `CDSDMA_D_BUF_M:  st_next.ch[c].baddr[15:8] =
                            mem_rdata_in;
                        `CDSDMA_D_BUF_H:  st_next.ch[c].baddr[19:16] =
                            mem_rdata_in[3:0];
                        `CDSDMA_D_LEN_L:  st_next.ch[c].byte_counter[7:0] =
                            mem_rdata_in;
                        `CDSDMA_D_LEN_H:  st_next.ch[c].byte_counter[15:8] =
                            mem_rdata_in;
                        `CDSDMA_D_STAT:   st_next.ch[c].dstat =
                            mem_rdata_in;
                        default: ;
                    endcase
                    // Byte n+5 is reserved and skipped
                    st_next.ch[c].idx = (st_reg.ch[c].idx == `CDSDMA_D_BUF_H)
                        ? `CDSDMA_D_LEN_L : st_reg.ch[c].idx + 4'h1;
                    if (!c && st_reg.ch[c].idx == `CDSDMA_D_BUF_H) begin
                        // Receive needs no length or status from memory
                        st_next.ch[0].byte_counter =
                            st_reg.receive_buffer_length;
                        st_next.ch[0].phase = cdsdma_pkg::PH_XFER;
                    end
                    if (c && st_reg.ch[c].idx == `CDSDMA_D_STAT) begin
                        st_next.ch[1].phase = cdsdma_pkg::PH_XFER;
                    end
                end
                cdsdma_pkg::PH_XFER: begin
                    st_next.ch[c].baddr = st_reg.ch[c].baddr + 20'h0_0001;
                    st_next.ch[c].byte_counter =
                        st_reg.ch[c].byte_counter - 16'h0001;
                    fin = st_reg.ch[c].byte_counter == 16'h0001;
                    if (!c) begin
                        // Full buffer or frame end both switch buffers
                        if (fin || st_reg.ch[0].eof) begin
                            st_next.ch[0].phase = cdsdma_pkg::PH_WBACK;
                            st_next.ch[0].idx   = `CDSDMA_D_LEN_L;
                        end
                    end else begin
                        // Buffers stream back to back; a buffer with end of message closes the frame
                        push[1]  = 1'b1;
                        pdata[1] = {fin && st_reg.ch[1].dstat[`CDSDMA_ST_EOM],
                                    mem_rdata_in};
                        if (fin) begin
                            st_next.ch[1].current_descriptor_address =
                                st_reg.ch[1].link;
                            if (st_reg.ch[1].multi ?
                                st_reg.ch[1].dstat[`CDSDMA_ST_EOT] :
                                st_reg.ch[1].dstat[`CDSDMA_ST_EOM]) begin
                                st_next.ch[1].phase =
                                    cdsdma_pkg::PH_IDLE;
                            end else begin
                                st_next.ch[1].phase = cdsdma_pkg::PH_NEXT;
                            end
                        end
                    end
                end
                cdsdma_pkg::PH_WBACK: begin
                    st_next.ch[0].idx = st_reg.ch[0].idx + 4'h1;
                    if (st_reg.ch[0].idx == `CDSDMA_D_STAT) begin
                        st_next.ch[0].current_descriptor_address =
                            st_reg.ch[0].link;
                        st_next.ch[0].eof = 1'b0;
                        st_next.ch[0].phase =
                            (!st_reg.ch[0].multi && st_reg.ch[0].eof)
                            ? cdsdma_pkg::PH_IDLE : cdsdma_pkg::PH_NEXT;
                    end
                end
                default: ;
            endcase
        end

        // Issue a new memory op; receive has priority to avoid overrun
        ready[0] = (st_reg.ch[0].phase == cdsdma_pkg::PH_FETCH)
                 || (st_reg.ch[0].phase == cdsdma_pkg::PH_WBACK)
                 || (st_reg.ch[0].phase == cdsdma_pkg::PH_XFER
                     && st_reg.fifo[0].cnt != 2'h0);
        ready[1] = (st_reg.ch[1].phase == cdsdma_pkg::PH_FETCH)
                 || (st_reg.ch[1].phase == cdsdma_pkg::PH_XFER
                     && st_reg.fifo[1].cnt != `CDSDMA_FIFO_DEPTH);
        if (!st_reg.mem.req && ready != 2'b00) begin
            c = !ready[0];
            st_next.owner   = c;
            st_next.mem.req = 1'b1;
            st_next.mem.we  = 1'b0;
            st_next.mem.wdata = 8'h00;
            // Descriptor bytes sit under the chain pointer base
            st_next.mem.addr = {st_reg.ch[c].chain_pointer_base,
                st_reg.ch[c].current_descriptor_address
                + {12'h000, st_reg.ch[c].idx}};
            case (st_reg.ch[c].phase)
                cdsdma_pkg::PH_XFER: begin
                    st_next.mem.addr = st_reg.ch[c].baddr;
                    if (!c) begin
                        pop[0] = 1'b1;
                        st_next.mem.we    = 1'b1;
                        st_next.mem.wdata =
                            st_reg.fifo[0].ent[st_reg.fifo[0].head][7:0];
                        st_next.ch[0].eof =
                            st_reg.fifo[0].ent[st_reg.fifo[0].head][8];
                    end
                end
                cdsdma_pkg::PH_WBACK: begin
                    st_next.mem.we = 1'b1;
                    case (st_reg.ch[0].idx)
                        `CDSDMA_D_LEN_L: st_next.mem.wdata =
                            used[7:0];
                        `CDSDMA_D_LEN_H: st_next.mem.wdata =
                            used[15:8];
                        default: st_next.mem.wdata = st_reg.ch[0].eof
                            ? st_reg.fstat : `CDSDMA_STAT_MID;
                    endcase
                end
                default: ;
            endcase
        end

        // FIFO bookkeeping for both paths
        for (int p = 0; p < 2; p++) begin
            // Sum in three bits: head 2 plus count 2 must land on slot 1
            tail_sum = {1'b0, st_reg.fifo[p].head}
                     + {1'b0, st_reg.fifo[p].cnt};
            if (tail_sum > 3'h2) begin
                tail_sum = tail_sum - 3'h3;
            end
            tail = tail_sum[1:0];
            if (push[p]) begin
                st_next.fifo[p].ent[tail] = pdata[p];
            end
            if (pop[p]) begin
                st_next.fifo[p].head = (st_reg.fifo[p].head == 2'h2)
                    ? 2'h0 : st_reg.fifo[p].head + 2'h1;
            end
            st_next.fifo[p].cnt = st_reg.fifo[p].cnt
                + {1'b0, push[p]} - {1'b0, pop[p]};
        end
    end

    // =================================================================
    // State register, synchronous active-low reset
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
            st_reg.ch[0].phase <= cdsdma_pkg::PH_IDLE;
            st_reg.ch[1].phase <= cdsdma_pkg::PH_IDLE;
            st_reg.receive_buffer_length <= `CDSDMA_RST_BFL;
        end else begin
            st_reg <= st_next;
        end
    end

    // =================================================================
    // Checks
    logic ack0, ack1; // Completion for each channel
    assign ack0 = st_reg.mem.req && mem_ack_in && !st_reg.owner;
    assign ack1 = st_reg.mem.req && mem_ack_in && st_reg.owner;
    logic eom_due; // Byte in flight closes a message-end buffer
    assign eom_due = st_reg.ch[1].byte_counter == 16'h0001
                  && st_reg.ch[1].dstat[`CDSDMA_ST_EOM];

    sequence s_rx_last_byte;
        ack0 && st_reg.ch[0].phase == cdsdma_pkg::PH_XFER
             && (st_reg.ch[0].eof || st_reg.ch[0].byte_counter == 16'h0001);
    endsequence
    sequence s_rx_wback;
        st_reg.ch[0].phase == cdsdma_pkg::PH_WBACK
            && st_reg.ch[0].idx == `CDSDMA_D_LEN_L;
    endsequence

    a_rx_buf_switch: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in) s_rx_last_byte |=> s_rx_wback)
        else $error("receive buffer did not switch");
    a_desc_base_bits: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        $rose(st_reg.mem.req) && st_reg.ch[st_reg.owner].phase
            == cdsdma_pkg::PH_FETCH |-> st_reg.mem.addr[19:16]
            == st_reg.ch[st_reg.owner].chain_pointer_base)
        else $error("descriptor address top bits wrong");
    a_end_match_stop: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        st_reg.ch[1].phase == cdsdma_pkg::PH_NEXT
        && st_reg.ch[1].current_descriptor_address
            == st_reg.ch[1].end_descriptor_address
        |=> st_reg.ch[1].phase == cdsdma_pkg::PH_IDLE [*2])
        else $error("channel ran past end descriptor");
    a_mid_frame_stat: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        $rose(st_reg.mem.req) && !st_reg.owner && st_reg.mem.we
        && st_reg.ch[0].phase == cdsdma_pkg::PH_WBACK
        && st_reg.ch[0].idx == `CDSDMA_D_STAT && !st_reg.ch[0].eof
        |-> st_reg.mem.wdata == 8'h00)
        else $error("mid-frame status not zero");
    a_rx_cnt_reload: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        $rose(st_reg.ch[0].phase == cdsdma_pkg::PH_XFER)
        |-> st_reg.ch[0].byte_counter == $past(st_reg.receive_buffer_length))
        else $error("receive counter not reloaded");
    a_cnt_decrement: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        ack1 && st_reg.ch[1].phase == cdsdma_pkg::PH_XFER
        |=> st_reg.ch[1].byte_counter
            == $past(st_reg.ch[1].byte_counter) - 16'h0001)
        else $error("byte counter did not decrement");
    a_rx_fifo_full: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        st_reg.fifo[0].cnt == 2'h3 |-> !rx_ready_out ##1
            st_reg.fifo[0].cnt != 2'h0)
        else $error("receive FIFO overfilled");
    a_eot_stop: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        ack1 && st_reg.ch[1].phase == cdsdma_pkg::PH_XFER
        && st_reg.ch[1].multi && st_reg.ch[1].dstat[`CDSDMA_ST_EOT]
        && st_reg.ch[1].byte_counter == 16'h0001
        |=> st_reg.ch[1].phase == cdsdma_pkg::PH_IDLE)
        else $error("transmit did not stop at end of transfer");
    a_tx_eom_mark: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        ack1 && st_reg.ch[1].phase == cdsdma_pkg::PH_XFER
        |=> st_reg.fifo[1].ent[$past(tail)]
            == {$past(eom_due), $past(mem_rdata_in)})
        else $error("transmit byte or frame end mark wrong");

endmodule : cdsdma

// >>> cdsdma_mem_model.sv
// Byte-wide memory model on the engine's master port
`timescale 1ns/1ns
module cdsdma_mem_model (
    input  wire logic                    clk_in,
    input  wire cdsdma_pkg::cdsdma_mem_s req_in,
    output logic                         ack_out = 1'b0,
    output logic [7:0]                   rdata_out
);
    logic [7:0] mem [1048576];  // Whole 20-bit space
    // Off an ack the data lines wander so stale bytes never match
    assign rdata_out = ack_out ? mem[req_in.addr] : ~req_in.addr[7:0];
    // Random stalls exercise both prompt and slow answers
    always @(posedge clk_in) begin
        ack_out <= req_in.req & ~ack_out & 1'($urandom);
        if (req_in.req & ack_out & req_in.we) begin
            mem[req_in.addr] <= req_in.wdata;
        end
    end
endmodule : cdsdma_mem_model

// >>> cdsdma_tb.sv
// Self-checking bench for the chained descriptor DMA engine
`timescale 1ns/1ns
module cdsdma_tb;
    logic clk_sys_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
    logic [4:0] reg_addr_in = 0;
    logic [15:0] reg_wdata_in = 0, reg_rdata_out;
    logic rx_valid_in = 0, rx_eof_in = 0, tx_ready_in = 0, rd_d = 0;
    logic [7:0] rx_data_in = 0, rx_status_in = 0, tx_data_out, mem_rdata_in;
    logic rx_ready_out, tx_valid_out, tx_eom_out, mem_ack_in;
    cdsdma_pkg::cdsdma_mem_s mem_out;
    logic [15:0] rq[$];  // Expected read data
    logic [8:0] tq[$];   // Expected end flag and byte
    logic [7:0] rb [3];
    logic [19:0] ba [3] = '{20'hF_FFFE, 20'h2_0000, 20'h3_0000};
    logic [15:0] ln [3] = '{16'h0002, 16'h0003, 16'h0001};
    int fail_count = 0, checks_done = 0;
    always #2 clk_sys_in = ~clk_sys_in;
    cdsdma uut (.*);
    cdsdma_mem_model mm (.clk_in(clk_sys_in), .req_in(mem_out),
        .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // One register access; a read notes its expected data
    task automatic bus(logic w, logic [4:0] a, logic [15:0] d);
        reg_wr_in <= w;
        reg_rd_in <= !w;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        if (!w) rq.push_back(d);
        @(posedge clk_sys_in);
        reg_wr_in <= 0;
        reg_rd_in <= 0;
        @(posedge clk_sys_in);
    endtask : bus
    // Reserved bytes are set to ones; the engine must ignore them
    task automatic desc(logic [19:0] a, logic [15:0] lk, logic [19:0] b,
        logic [15:0] l, logic [7:0] st);
        logic [71:0] v;
        v = {st, l, 8'hFF, 4'hF, b, lk};
        for (int i = 0; i < 9; i++) mm.mem[a + i] = v[8 * i +: 8];
    endtask : desc
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // Result watcher; the transmitter stalls at random
    always @(posedge clk_sys_in) begin
        if (rd_d) chk("rdata", reg_rdata_out, rq.pop_front());
        if (tx_valid_out & tx_ready_in)
            chk("tx", 16'({tx_eom_out, tx_data_out}),
                16'(tq.pop_front()));
        rd_d <= reg_rd_in;
        tx_ready_in <= 1'($urandom);
    end
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fail_count++;
        results();
    end
    initial begin
        logic [7:0] b;
        logic [7:0] rs;
        void'($urandom(82717));
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1;
        // Transmit: single frame, multi-frame to end flag, end address
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 3; k++) begin
                desc(20'h1_0000 + 10 * k, 16'(10 * k + 10), ba[k], ln[k],
                    k == 0 ? 8'h00 : 8'(64 * k + 64));
                for (int i = 0; i < ln[k]; i++) begin
                    b = 8'($urandom);
                    mm.mem[ba[k] + i] = b;
                    if (k < 2 + (m == 1))
                        tq.push_back({k > 0 && i == ln[k] - 1, b});
                end
            end
            bus(1, 5'h08, 16'h0001);
            bus(1, 5'h09, 16'h0000);
            bus(1, 5'h0A, m == 2 ? 16'h0014 : 16'h0030);
            bus(1, 5'h0B, m ? 16'h0003 : 16'h0001);
            for (int t = 0; t < 900 && tq.size(); t++) @(posedge clk_sys_in);
            repeat (20) @(posedge clk_sys_in);
            chk("txleft", 16'(tq.size()), 16'h0000);
            bus(0, 5'h09, m == 1 ? 16'h001E : 16'h0014);
            bus(0, 5'h0D, 16'h0001);
        end
        bus(0, 5'h1F, 16'h0000);
        // Receive: three-byte frame into two-byte buffers
        desc(20'h1_0100, 16'h0110, 20'h4_0000, 16'hFFFF, 8'hFF);
        desc(20'h1_0110, 16'h0120, 20'h4_1000, 16'hFFFF, 8'hFF);
        bus(1, 5'h10, 16'h0002);
        bus(1, 5'h00, 16'h0001);
        bus(1, 5'h01, 16'h0100);
        bus(1, 5'h02, 16'h0200);
        bus(1, 5'h03, 16'h0001);
        rs = 8'($urandom);
        rx_status_in <= rs;
        for (int i = 0; i < 3; i++) begin
            rb[i] = 8'($urandom);
            rx_valid_in <= 1;
            rx_data_in <= rb[i];
            rx_eof_in <= i == 2;
            do @(posedge clk_sys_in); while (!rx_ready_out);
        end
        rx_valid_in <= 0;
        for (int t = 0; t < 900 && mm.mem[20'h1_0118] !== rs; t++)
            @(posedge clk_sys_in);
        repeat (4) @(posedge clk_sys_in);
        for (int i = 0; i < 3; i++)
            chk("rxbuf", 16'(mm.mem[i < 2 ? 20'h4_0000 + i : 20'h4_1000]),
                16'(rb[i]));
        chk("len0", {mm.mem[20'h1_0107], mm.mem[20'h1_0106]},
            16'h0002);
        chk("st0", 16'(mm.mem[20'h1_0108]), 16'h0000);
        chk("len1", {mm.mem[20'h1_0117], mm.mem[20'h1_0116]},
            16'h0001);
        chk("st1", 16'(mm.mem[20'h1_0118]), 16'(rs));
        bus(0, 5'h01, 16'h0120);
        // Let the watcher take the last read before the verdict
        repeat (2) @(posedge clk_sys_in);
        results();
    end
endmodule : cdsdma_tb
